// ==== hdl/mcs_core.sv ====
// Sequencer, decoder, register file, accumulator ALU and ports of the controller core.
// Assumes all pins synchronous to sys_clk; program words are loaded over the software port.
//
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
module mcs_core
   import mcs_pkg::*;
(
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic clkEn,
   input wire logic masterClear_n,
   input wire logic eventCounterPin_n,
   input wire logic [3:0] inputPortA,
   output logic [7:0] outputPortB,
   input wire logic [7:0] bidirPortCIn,
   output logic [7:0] bidirPortCOut,
   output logic [7:0] bidirPortCOe,
   output logic clkOut,
   input wire logic [9:0] busAddr,
   input wire logic [11:0] busWrData,
   input wire logic busWr,
   input wire logic busRd,
   output logic [11:0] busRdData
);

   ////////////////////////////////////////////////////////////////////////////////
   // Storage

   mcs_core_t q;
   mcs_core_t d;
   logic [11:0] pmem [PMEM_WORDS];
   logic [7:0] gpr [FILE_REGS];
   logic gprWe;
   logic [4:0] gprWa;
   logic [7:0] gprWd;

   logic eventFall;
   logic [11:0] ir;
   logic [4:0] fa;
   logic [7:0] opVal;
   logic [7:0] busVal;

   ////////////////////////////////////////////////////////////////////////////////
   // File read path

   // Value of one file register as seen by an instruction
   function automatic logic [7:0] readFile(
      input logic [4:0] a,
      input mcs_core_t s,
      input logic [7:0] g,
      input logic [3:0] pa,
      input logic [7:0] pcPins
   );
      logic [7:0] v;
      v = g;
      case (a)
         F_INDIRECT: v = 8'h00;
         F_COUNTER: v = s.counter;
         F_PCL: v = s.pc[7:0];
         F_STATUS: v = s.status;
         F_FSR: v = {3'h0, s.fsr};
         F_PORTA: v = {4'h0, pa};
         F_PORTB: v = s.latB;
         F_PORTC: v = pcPins;
         default: v = g;
      endcase
      return v;
   endfunction : readFile

   // Event counter edge
   mcs_fall_detect uEdge (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .clkEn(clkEn),
      .pinIn(eventCounterPin_n),
      .fallPulse(eventFall)
   );

   // Fetch and operand select
   assign ir = pmem[q.pc];
   assign fa = (ir[4:0] == F_INDIRECT) ? q.fsr : ir[4:0];
   assign opVal = readFile(fa, q, gpr[fa], inputPortA, bidirPortCIn);
   assign busVal = readFile(busAddr[4:0], q, gpr[busAddr[4:0]], inputPortA, bidirPortCIn);

   ////////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      logic [7:0] res;
      logic [8:0] sum;
      logic [4:0] nib;
      logic [7:0] mask;
      logic toFile;
      logic toW;
      logic zUpd;
      logic cUpd;
      logic doSkip;
      logic jump;
      logic c;
      logic dc;
      res = 8'h00;
      sum = 9'h000;
      nib = 5'h00;
      mask = 8'h01 << ir[7:5];
      toFile = 1'b0;
      toW = 1'b0;
      zUpd = 1'b0;
      cUpd = 1'b0;
      doSkip = 1'b0;
      jump = 1'b0;
      c = q.status[ST_C];
      dc = q.status[ST_DC];
      d = q;
      gprWe = 1'b0;
      gprWa = fa;
      gprWd = 8'h00;

      // Event counter
      if (eventFall) begin
         d.counter = q.counter + 8'h01;
      end

      // Instruction cycle phase
      if (q.phase == PHASE_LAST) begin
         d.phase = 3'h0;
      end else begin
         d.phase = q.phase + 3'h1;
      end

      // Software read port, data in the following cycle only
      d.rdData = 12'h000;
      if (busRd) begin
         if (!busAddr[9]) begin
            d.rdData = pmem[busAddr[8:0]];
         end else if (busAddr[9:5] == BUS_FILE_BASE[9:5]) begin
            d.rdData = {4'h0, busVal};
         end else if (busAddr == BUS_W_ADDR) begin
            d.rdData = {4'h0, q.w};
         end else if (busAddr == BUS_PC_ADDR) begin
            d.rdData = {3'h0, q.pc};
         end
      end

      // Discarded second cycle after a skip or flow change
      if (q.phase == PHASE_LAST && q.st == ST_FLUSH) begin
         d.st = ST_EXEC;
      end

      // Execute at the end of each instruction cycle that is not being discarded
      if (q.phase == PHASE_LAST && q.st == ST_EXEC) begin
         d.pc = q.pc + 9'h001;
         unique casez (ir[11:8])
            OP_BYTE: begin
               toFile = ir[5];
               toW = !ir[5];
               zUpd = 1'b1;
               unique case (ir[9:6])
                  BOP_ACCUMULATOR_STORE_OP: begin
                     res = q.w;
                     toW = 1'b0;
                     zUpd = 1'b0;
                  end
                  BOP_CLR: res = 8'h00;
                  BOP_SUB: begin
                     sum = {1'b0, opVal} - {1'b0, q.w};
                     res = sum[7:0];
                     c = !sum[8];
                     dc = opVal[3:0] >= q.w[3:0];
                     cUpd = 1'b1;
                  end
                  BOP_DEC: res = opVal - 8'h01;
                  BOP_IOR: res = opVal | q.w;
                  BOP_AND: res = opVal & q.w;
                  BOP_XOR: res = opVal ^ q.w;
                  BOP_ADD: begin
                     sum = {1'b0, opVal} + {1'b0, q.w};
                     nib = {1'b0, opVal[3:0]} + {1'b0, q.w[3:0]};
                     res = sum[7:0];
                     c = sum[8];
                     dc = nib[4];
                     cUpd = 1'b1;
                  end
                  BOP_MOV: res = opVal;
                  BOP_COM: res = ~opVal;
                  BOP_INC: res = opVal + 8'h01;
                  BOP_DECSZ: begin
                     res = opVal - 8'h01;
                     zUpd = 1'b0;
                     doSkip = (res == 8'h00);
                  end
                  BOP_RRF: begin
                     res = {q.status[ST_C], opVal[7:1]};
                     c = opVal[0];
                     dc = q.status[ST_DC];
                     cUpd = 1'b1;
                     zUpd = 1'b0;
                  end
                  BOP_RLF: begin
                     res = {opVal[6:0], q.status[ST_C]};
                     c = opVal[7];
                     dc = q.status[ST_DC];
                     cUpd = 1'b1;
                     zUpd = 1'b0;
                  end
                  BOP_SWAP: begin
                     res = {opVal[3:0], opVal[7:4]};
                     zUpd = 1'b0;
                  end
                  BOP_INCSZ: begin
                     res = opVal + 8'h01;
                     zUpd = 1'b0;
                     doSkip = (res == 8'h00);
                  end
               endcase
            end
            OP_BIT: begin
               unique case (ir[9:8])
                  BIT_CLR: begin
                     res = opVal & ~mask;
                     toFile = 1'b1;
                  end
                  BIT_SET: begin
                     res = opVal | mask;
                     toFile = 1'b1;
                  end
                  BIT_TSTC: doSkip = ((opVal & mask) == 8'h00);
                  BIT_TSTS: doSkip = ((opVal & mask) != 8'h00);
               endcase
            end
            OP_RETLW: begin
               d.w = ir[7:0];
               d.pc = q.stk0;
               d.stk0 = q.stk1;
               jump = 1'b1;
            end
            OP_CALL: begin
               d.stk1 = q.stk0;
               d.stk0 = q.pc + 9'h001;
               d.pc = {1'b0, ir[7:0]};
               jump = 1'b1;
            end
            OP_GOTO: begin
               d.pc = ir[8:0];
               jump = 1'b1;
            end
            OP_MOVLW: d.w = ir[7:0];
            OP_IORLW: begin
               res = ir[7:0] | q.w;
               d.w = res;
               zUpd = 1'b1;
            end
            OP_ANDLW: begin
               res = ir[7:0] & q.w;
               d.w = res;
               zUpd = 1'b1;
            end
            OP_XORLW: begin
               res = ir[7:0] ^ q.w;
               d.w = res;
               zUpd = 1'b1;
            end
         endcase

         // Status flags, overridden below when status itself is the target
         if (zUpd) begin
            d.status[ST_Z] = (res == 8'h00);
         end
         if (cUpd) begin
            d.status[ST_C] = c;
            d.status[ST_DC] = dc;
         end

         // Result to accumulator
         if (toW) begin
            d.w = res;
         end

         // Result to file register
         if (toFile) begin
            unique case (fa)
               F_INDIRECT: begin
               end
               F_COUNTER: d.counter = res;
               F_PCL: begin
                  d.pc = {1'b0, res};
                  jump = 1'b1;
               end
               F_STATUS: d.status = res;
               F_FSR: d.fsr = res[4:0];
               F_PORTA: begin
               end
               F_PORTB: d.latB = res;
               F_PORTC: begin
                  d.latC = res;
                  d.oeC = ~res;
               end
               default: begin
                  gprWe = 1'b1;
                  gprWd = res;
               end
            endcase
         end

         // Skip discards the next word; flow changes cost one more cycle
         if (doSkip) begin
            d.pc = q.pc + 9'h002;
         end
         if (doSkip || jump) begin
            d.st = ST_FLUSH;
         end
      end

      // Master clear
      if (!masterClear_n) begin
         d.pc = RESET_VECTOR;
         d.latB = PORT_RESET;
         d.latC = PORT_RESET;
         d.oeC = ~PORT_RESET;
         d.phase = 3'h0;
         d.st = ST_EXEC;
         gprWe = 1'b0;
      end

      // Clock output high for the first half of each instruction cycle
      d.clkOut = (d.phase < PHASE_HALF);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Registers

   // Core state
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         q <= '{
            st: ST_EXEC,
            phase: 3'h0,
            pc: RESET_VECTOR,
            stk0: RESET_VECTOR,
            stk1: RESET_VECTOR,
            w: 8'h00,
            status: STATUS_RESET,
            counter: 8'h00,
            latB: PORT_RESET,
            latC: PORT_RESET,
            oeC: ~PORT_RESET,
            fsr: 5'h00,
            clkOut: 1'b1,
            rdData: 12'h000
         };
      end else if (clkEn) begin
         q <= d;
      end
   end

   // General registers
   always_ff @(posedge sys_clk) begin
      if (clkEn && gprWe) begin
         gpr[gprWa] <= gprWd;
      end
   end

   // Program memory load from the software port
   always_ff @(posedge sys_clk) begin
      if (clkEn && busWr && !busAddr[9]) begin
         pmem[busAddr[8:0]] <= busWrData;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign outputPortB = q.latB;
   assign bidirPortCOut = q.latC;
   assign bidirPortCOe = q.oeC;
   assign clkOut = q.clkOut;
   assign busRdData = q.rdData;

endmodule : mcs_core

// ==== hdl/mcs_pkg.sv ====
// Shared constants and types for the small controller core sequencer.
// Assumes a single sys_clk domain at 20 MHz and an asynchronous active-low reset.
package mcs_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int CLK_PERIOD_NS = 50;
   localparam int INSTR_CYCLE_NS = 400;
   localparam int CYCLE_CLKS = (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [2:0] PHASE_LAST = 3'(CYCLE_CLKS - 1);
   localparam logic [2:0] PHASE_HALF = 3'(CYCLE_CLKS / 2);

   ////////////////////////////////////////////////////////////////////////////////
   // Sizes and reset values
   localparam int PMEM_WORDS = 512;
   localparam int FILE_REGS = 32;
   localparam logic [8:0] RESET_VECTOR = 9'h1ff;
   localparam logic [7:0] PORT_RESET = 8'hff;
   localparam logic [7:0] STATUS_RESET = 8'h00;

   ////////////////////////////////////////////////////////////////////////////////
   // File register map
   localparam logic [4:0] F_INDIRECT = 5'h00;
   localparam logic [4:0] F_COUNTER = 5'h01;
   localparam logic [4:0] F_PCL = 5'h02;
   localparam logic [4:0] F_STATUS = 5'h03;
   localparam logic [4:0] F_FSR = 5'h04;
   localparam logic [4:0] F_PORTA = 5'h05;
   localparam logic [4:0] F_PORTB = 5'h06;
   localparam logic [4:0] F_PORTC = 5'h07;

   // Status bit positions
   localparam int ST_C = 0;
   localparam int ST_DC = 1;
   localparam int ST_Z = 2;

   ////////////////////////////////////////////////////////////////////////////////
   // Software port map
   localparam logic [9:0] BUS_FILE_BASE = 10'h200;
   localparam logic [9:0] BUS_W_ADDR = 10'h220;
   localparam logic [9:0] BUS_PC_ADDR = 10'h221;

   ////////////////////////////////////////////////////////////////////////////////
   // Instruction classes on ir[11:8]
   localparam logic [3:0] OP_BYTE = 4'b00??;
   localparam logic [3:0] OP_BIT = 4'b01??;
   localparam logic [3:0] OP_RETLW = 4'b1000;
   localparam logic [3:0] OP_CALL = 4'b1001;
   localparam logic [3:0] OP_GOTO = 4'b101?;
   localparam logic [3:0] OP_MOVLW = 4'b1100;
   localparam logic [3:0] OP_IORLW = 4'b1101;
   localparam logic [3:0] OP_ANDLW = 4'b1110;
   localparam logic [3:0] OP_XORLW = 4'b1111;

   // Byte operations on ir[9:6]
   localparam logic [3:0] BOP_ACCUMULATOR_STORE_OP = 4'h0;
   localparam logic [3:0] BOP_CLR = 4'h1;
   localparam logic [3:0] BOP_SUB = 4'h2;
   localparam logic [3:0] BOP_DEC = 4'h3;
   localparam logic [3:0] BOP_IOR = 4'h4;
   localparam logic [3:0] BOP_AND = 4'h5;
   localparam logic [3:0] BOP_XOR = 4'h6;
   localparam logic [3:0] BOP_ADD = 4'h7;
   localparam logic [3:0] BOP_MOV = 4'h8;
   localparam logic [3:0] BOP_COM = 4'h9;
   localparam logic [3:0] BOP_INC = 4'ha;
   localparam logic [3:0] BOP_DECSZ = 4'hb;
   localparam logic [3:0] BOP_RRF = 4'hc;
   localparam logic [3:0] BOP_RLF = 4'hd;
   localparam logic [3:0] BOP_SWAP = 4'he;
   localparam logic [3:0] BOP_INCSZ = 4'hf;

   // Bit operations on ir[9:8]
   localparam logic [1:0] BIT_CLR = 2'h0;
   localparam logic [1:0] BIT_SET = 2'h1;
   localparam logic [1:0] BIT_TSTC = 2'h2;
   localparam logic [1:0] BIT_TSTS = 2'h3;

   ////////////////////////////////////////////////////////////////////////////////
   // Types
   typedef enum logic {ST_EXEC, ST_FLUSH} mcs_state_t;

   typedef struct packed {
      mcs_state_t st;
      logic [2:0] phase;
      logic [8:0] pc;
      logic [8:0] stk0;
      logic [8:0] stk1;
      logic [7:0] w;
      logic [7:0] status;
      logic [7:0] counter;
      logic [7:0] latB;
      logic [7:0] latC;
      logic [7:0] oeC;
      logic [4:0] fsr;
      logic clkOut;
      logic [11:0] rdData;
   } mcs_core_t;

   typedef struct packed {
      logic prev;
   } mcs_edge_t;

endpackage : mcs_pkg

// ==== hdl/mcs_fall_detect.sv ====
// Falling-edge detector for the event counter pin.
// Assumes the pin is already synchronous to sys_clk.
`timescale 1ns/1ps
module mcs_fall_detect
   import mcs_pkg::*;
(
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic clkEn,
   input wire logic pinIn,
   output logic fallPulse
);

   mcs_edge_t q;
   mcs_edge_t d;

   // Previous pin level
   always_comb begin
      d = q;
      d.prev = pinIn;
   end

   // State register
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         q <= '{prev: 1'b1};
      end else if (clkEn) begin
         q <= d;
      end
   end

   // High before, low now
   assign fallPulse = clkEn & q.prev & ~pinIn;

endmodule : mcs_fall_detect

// ==== tb/mcs_core_assertions.sv ====
// Concurrent checks on the pins and software port of the controller core.
// Assumes one sys_clk domain; attached to every core instance by the bind below.
`timescale 1ns/1ps
module mcs_core_assertions
   import mcs_pkg::*;
(
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic clkEn,
   input wire logic masterClear_n,
   input wire logic [7:0] outputPortB,
   input wire logic [7:0] bidirPortCOut,
   input wire logic [7:0] bidirPortCOe,
   input wire logic clkOut,
   input wire logic [9:0] busAddr,
   input wire logic busRd,
   input wire logic [11:0] busRdData
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   ////////////////////////////////////////////////////////////////////////////////
   // Master clear effects on latches and program counter
   a_master_clear_n_latch_b: assert property (clkEn && !masterClear_n |=> outputPortB == 8'hff)
      else $error("port b latch not high after master clear");
   a_master_clear_n_latch_c: assert property (clkEn && !masterClear_n |=>
      bidirPortCOut == 8'hff && bidirPortCOe == 8'h00)
      else $error("port c latch not released after master clear");
   a_master_clear_n_vector: assert property ($past(busRd) && $past(busAddr) == 10'h221 &&
      !$past(masterClear_n) && !$past(masterClear_n, 2) |-> busRdData == 12'h1ff)
      else $error("program counter not at reset vector");

   ////////////////////////////////////////////////////////////////////////////////
   // Instruction timing and port c drive seen on the pins
   a_instr_period: assert property (@(posedge sys_clk)
      disable iff (!arst_n || !masterClear_n)
      $rose(clkOut) |-> clkOut[*4] ##1 (!clkOut)[*4] ##1 clkOut)
      else $error("clock output not four high and four low");
   a_port_b_edge: assert property ($changed(outputPortB) && $past(masterClear_n)
      |-> $rose(clkOut))
      else $error("port b changed away from an instruction boundary");
   a_portc_drive: assert property (bidirPortCOe == ~bidirPortCOut)
      else $error("port c enable disagrees with its latch");

   ////////////////////////////////////////////////////////////////////////////////
   // Widths of values read back
   a_file_width: assert property ($past(busRd) && $past(busAddr[9:5]) == 5'h10
      |-> busRdData[11:8] == 4'h0)
      else $error("file register wider than a byte");
   a_porta_upper: assert property ($past(busRd) && $past(busAddr) == 10'h205
      |-> busRdData[11:4] == 8'h00)
      else $error("input port upper bits not zero");
   a_pc_width: assert property ($past(busRd) && $past(busAddr) == 10'h221
      |-> busRdData[11:9] == 3'h0)
      else $error("program counter wider than nine bits");
endmodule : mcs_core_assertions

bind mcs_core mcs_core_assertions u_chk (.sys_clk(sys_clk), .arst_n(arst_n), .clkEn(clkEn),
   .masterClear_n(masterClear_n), .outputPortB(outputPortB), .bidirPortCOut(bidirPortCOut),
   .bidirPortCOe(bidirPortCOe), .clkOut(clkOut), .busAddr(busAddr), .busRd(busRd),
   .busRdData(busRdData));

// ==== tb/mcs_port_partner.sv ====
// Outside logic on the port lines: pulled-up port c, input port a, event pin.
// Assumes the bench sets the sink mask and port a level between instructions.
`timescale 1ns/1ps
module mcs_port_partner
   import mcs_pkg::*;
(
   input wire logic sys_clk,
   input wire logic [7:0] bidirPortCOe,
   input wire logic [7:0] pullLow,
   input wire logic [3:0] aLevel,
   output logic [7:0] bidirPortCIn,
   output logic [3:0] inputPortA,
   output logic eventCounterPin_n
);
   // Pulled-up wire, low where either side sinks it
   assign bidirPortCIn = ~(bidirPortCOe | pullLow);
   assign inputPortA = aLevel;
   initial eventCounterPin_n = 1'b1;

   // Falling edges, each level held a full instruction cycle
   task automatic fall_pulses(input int n);
      repeat (n) begin
         @(posedge sys_clk) eventCounterPin_n <= 1'b0;
         repeat (8) @(posedge sys_clk);
         eventCounterPin_n <= 1'b1;
         repeat (8) @(posedge sys_clk);
      end
   endtask : fall_pulses
endmodule : mcs_port_partner

// ==== tb/mcs_core_bench.sv ====
// Self-checking bench for the controller core: instruction rows, then timing, ports, event counter, stack.
// Assumes the port partner model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module mcs_core_bench
   import mcs_pkg::*;
();
   typedef struct packed {
      logic [11:0] op;
      logic [7:0] fa;
      logic [7:0] wb;
      logic [9:0] addr;
      logic [11:0] exp;
   } mcs_row_t;

   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   logic masterClear_n = 1'b0;
   logic [7:0] pullLow = 8'h00;
   logic [3:0] aLevel = 4'h0;
   logic [9:0] busAddr = 10'h000;
   logic [11:0] busWrData = 12'h000;
   logic busWr = 1'b0;
   logic busRd = 1'b0;
   logic [7:0] outputPortB, bidirPortCIn, bidirPortCOut, bidirPortCOe;
   logic [3:0] inputPortA;
   logic eventCounterPin_n, clkOut;
   logic [11:0] busRdData, rd;
   logic [21:0] prg [$];
   int failures = 0;
   int n_checks = 0;
   int t;
   // Op, file value, accumulator value, address read back, expected
   mcs_row_t rows [17] = '{
      '{12'h1d0, 8'h35, 8'h0a, 10'h220, 12'h03f}, '{12'h1f0, 8'h35, 8'h0a, 10'h210, 12'h03f},
      '{12'h0b0, 8'h40, 8'h01, 10'h210, 12'h03f}, '{12'h150, 8'hf0, 8'h3c, 10'h220, 12'h030},
      '{12'h110, 8'h0f, 8'h30, 10'h220, 12'h03f}, '{12'h1b0, 8'hff, 8'h0f, 10'h210, 12'h0f0},
      '{12'h250, 8'h5a, 8'h00, 10'h220, 12'h0a5}, '{12'h390, 8'h12, 8'h00, 10'h220, 12'h021},
      '{12'h5f0, 8'h00, 8'h00, 10'h210, 12'h080}, '{12'h410, 8'hff, 8'h00, 10'h210, 12'h0fe},
      '{12'hc77, 8'h00, 8'h00, 10'h220, 12'h077}, '{12'he0f, 8'h00, 8'h3c, 10'h220, 12'h00c},
      '{12'h610, 8'h01, 8'h00, 10'h221, 12'h004}, '{12'h610, 8'h00, 8'h00, 10'h221, 12'h005},
      '{12'h710, 8'h01, 8'h00, 10'h221, 12'h005}, '{12'h2f0, 8'h01, 8'h00, 10'h221, 12'h005},
      '{12'h022, 8'h00, 8'h05, 10'h221, 12'h005}};

   always #25 sys_clk = ~sys_clk;

   mcs_core dut (.sys_clk(sys_clk), .arst_n(arst_n), .clkEn(1'b1), .masterClear_n(masterClear_n),
      .eventCounterPin_n(eventCounterPin_n), .inputPortA(inputPortA), .outputPortB(outputPortB),
      .bidirPortCIn(bidirPortCIn), .bidirPortCOut(bidirPortCOut), .bidirPortCOe(bidirPortCOe),
      .clkOut(clkOut), .busAddr(busAddr), .busWrData(busWrData), .busWr(busWr), .busRd(busRd),
      .busRdData(busRdData));
   mcs_port_partner u_partner (.sys_clk(sys_clk), .bidirPortCOe(bidirPortCOe), .pullLow(pullLow),
      .aLevel(aLevel), .bidirPortCIn(bidirPortCIn), .inputPortA(inputPortA),
      .eventCounterPin_n(eventCounterPin_n));

   ////////////////////////////////////////////////////////////////////////////////
   // Shared tasks
   task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic bus_wr(input logic [9:0] a, input logic [11:0] d);
      @(posedge sys_clk) begin
         busAddr <= a;
         busWrData <= d;
         busWr <= 1'b1;
      end
      @(posedge sys_clk) busWr <= 1'b0;
   endtask : bus_wr

   task automatic bus_rd(input logic [9:0] a, output logic [11:0] d);
      @(posedge sys_clk) begin
         busAddr <= a;
         busRd <= 1'b1;
      end
      @(posedge sys_clk) busRd <= 1'b0;
      #1 d = busRdData;
   endtask : bus_rd

   // Load the program under master clear, release, let it run
   task automatic run_prog(input int n);
      @(posedge sys_clk) masterClear_n <= 1'b0;
      bus_wr(10'h1ff, 12'ha00);
      foreach (prg[i]) bus_wr(prg[i][21:12], prg[i][11:0]);
      repeat (8) @(posedge sys_clk);
      masterClear_n <= 1'b1;
      repeat (n) @(posedge sys_clk);
   endtask : run_prog

   task automatic wait_b(input logic [7:0] v, output int n);
      // Sample just after the edge, once the latch has settled
      for (n = 0; n < 400 && outputPortB !== v; n++) begin
         @(posedge sys_clk);
         #1;
      end
   endtask : wait_b

   task automatic end_sim();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : end_sim

   ////////////////////////////////////////////////////////////////////////////////
   // Watchdog on the whole run
   initial begin
      repeat (40000) @(posedge sys_clk);
      failures++;
      end_sim();
   end

   // Main sequence
   initial begin
      repeat (2) @(posedge sys_clk);
      arst_n <= 1'b1;
      @(posedge sys_clk);
      #1 check("port b reset", {4'h0, outputPortB}, {4'h0, PORT_RESET});
      check("port c reset", {4'h0, bidirPortCOe}, 12'h000);
      bus_rd(BUS_PC_ADDR, rd);
      check("reset vector", rd, {3'h0, RESET_VECTOR});
      bus_rd(10'h3ff, rd);
      check("unmapped read", rd, 12'h000);
      repeat (20000) @(posedge sys_clk);
      foreach (rows[i]) begin
         prg = '{{10'h000, 4'hc, rows[i].fa}, {10'h001, 12'h030}, {10'h002, 4'hc, rows[i].wb},
            {10'h003, rows[i].op}, {10'h004, 12'ha04}, {10'h005, 12'ha05}};
         run_prog(100);
         bus_rd(rows[i].addr, rd);
         check("row result", rd, rows[i].exp);
      end
      // Spacing of port writes, plain and across a jump
      prg = '{{10'h000, 12'hc01}, {10'h001, 12'h026}, {10'h002, 12'hc02}, {10'h003, 12'h026},
         {10'h004, 12'ha05}, {10'h005, 12'h2a6}, {10'h006, 12'ha06}};
      run_prog(0);
      wait_b(8'h01, t);
      wait_b(8'h02, t);
      check("step time", 12'(t), 12'h010);
      wait_b(8'h03, t);
      check("jump time", 12'(t), 12'h018);
      // Bit set on port c with a pin held low, then input port read
      pullLow <= 8'h01;
      aLevel <= 4'ha;
      prg = '{{10'h000, 12'h5a7}, {10'h001, 12'h205}, {10'h002, 12'h031}, {10'h003, 12'ha03}};
      run_prog(80);
      check("port c drive", {4'h0, bidirPortCOe}, 12'h001);
      check("port c latch", {4'h0, bidirPortCOut}, 12'h0fe);
      bus_rd(10'h211, rd);
      check("port a by instruction", rd, 12'h00a);
      aLevel <= 4'hf;
      bus_rd(10'h205, rd);
      check("port a pins", rd, 12'h00f);
      pullLow <= 8'h00;
      // Event counter loaded by an instruction, then counting edges
      prg = '{{10'h000, 12'hc40}, {10'h001, 12'h021}, {10'h002, 12'ha02}};
      run_prog(60);
      u_partner.fall_pulses(3);
      bus_rd(10'h201, rd);
      check("event count", rd, 12'h043);
      // Two nested calls and their returns
      prg = '{{10'h000, 12'h910}, {10'h001, 12'h031}, {10'h002, 12'ha02}, {10'h010, 12'h920},
         {10'h011, 12'h855}, {10'h020, 12'h866}};
      run_prog(200);
      bus_rd(10'h211, rd);
      check("nested return", rd, 12'h055);
      bus_rd(BUS_PC_ADDR, rd);
      check("return address", rd, 12'h002);
      // Call from the upper half lands in the lower half, returns above
      prg = '{{10'h000, 12'hb80}, {10'h180, 12'h940}, {10'h181, 12'hb81}, {10'h140, 12'hb40},
         {10'h040, 12'h801}};
      run_prog(150);
      bus_rd(BUS_PC_ADDR, rd);
      check("call page", rd, 12'h181);
      end_sim();
   end
endmodule : mcs_core_bench
